// >>> dv/dual_dac_chk.sv
`timescale 1ns/1ns
module dual_dac_chk #(
   parameter int WAKE_CYCLES = 500
) (
   input wire logic aclk,
   input wire logic aresetn,
   input wire logic port_mode_select,
   input wire logic channel1_update_clock,
   input wire logic channel2_update_clock,
   input wire logic power_down,
   input wire logic [7:0] true_current_output_1,
   input wire logic [7:0] complement_current_output_1,
   input wire logic [7:0] true_current_output_2,
   input wire logic [7:0] complement_current_output_2,
   input wire logic current_enable,
   input wire logic low_power_state
);
   localparam int WAKE_MAX = WAKE_CYCLES + 4;
   logic c1_prev, c2_prev, up1, up2, up1_d, up2_d;
   default clocking cb @(posedge aclk); endclocking
   default disable iff (!aresetn);
   // Outputs may move only two edges after an update edge
   always_ff @(posedge aclk) begin
      c1_prev <= channel1_update_clock;
      c2_prev <= channel2_update_clock;
      up1 <= channel1_update_clock && !c1_prev;
      up2 <= port_mode_select ? channel2_update_clock && !c2_prev : channel1_update_clock && !c1_prev;
      up1_d <= up1;
      up2_d <= up2;
   end
   sequence s_steady;
      current_enable && $past(current_enable) && $past(current_enable, 2);
   endsequence
   sequence s_phase_high;
      (!port_mode_select && channel2_update_clock) [*3];
   endsequence
   a_sleep_fast: assert property (power_down |=> !current_enable && low_power_state)
      else $error("Sleep request not obeyed in one cycle");
   a_sleep_hold: assert property (power_down [*2] |-> !current_enable)
      else $error("Current on while sleep held");
   a_sleep_zero: assert property (!current_enable |-> (true_current_output_1 | complement_current_output_1 |
      true_current_output_2 | complement_current_output_2) == 8'h00)
      else $error("Outputs not zero while current off");
   a_compl_sum: assert property (s_steady |-> complement_current_output_1 == 8'hFF - true_current_output_1 &&
      complement_current_output_2 == 8'hFF - true_current_output_2)
      else $error("Complement output does not match code");
   a_wake_time: assert property ($fell(power_down) |=> low_power_state [*3] ##[1:WAKE_MAX] current_enable)
      else $error("Wake timing wrong");
   a_ch1_update: assert property (s_steady ##0 $changed(true_current_output_1) |-> up1_d)
      else $error("Channel 1 output moved without update");
   a_ch2_update: assert property (s_steady ##0 $changed(true_current_output_2) |-> up2_d)
      else $error("Channel 2 output moved without update");
   a_phase_block: assert property (s_phase_high ##0 s_steady |->
      $stable(true_current_output_1) && $stable(true_current_output_2))
      else $error("Output moved during phase reset");
endmodule // dual_dac_chk
bind dual_dac_input_latch_interface dual_dac_chk #(.WAKE_CYCLES(WAKE_CYCLES)) chk_u (.aclk, .aresetn,
   .port_mode_select, .channel1_update_clock, .channel2_update_clock, .power_down, .true_current_output_1,
   .complement_current_output_1, .true_current_output_2, .complement_current_output_2, .current_enable,
   .low_power_state);

// >>> dv/sample_source.sv
`timescale 1ns/1ns
// ****************
// Far side data driver
// ****************
module sample_source (
   input wire logic aclk,
   output logic port_mode_select,
   output logic [7:0] channel1_data,
   output logic [7:0] channel2_data,
   output logic channel1_input_strobe,
   output logic channel1_update_clock,
   output logic channel2_input_strobe,
   output logic channel2_update_clock,
   output logic power_down
);
   initial begin
      port_mode_select = 1'b1;
      {channel1_data, channel2_data} = 16'h0;
      {channel1_input_strobe, channel1_update_clock} = 2'h0;
      {channel2_input_strobe, channel2_update_clock, power_down} = 3'h0;
   end
   // data held past the capture, then released
   task automatic put(input logic two, input logic [7:0] w);
      @(posedge aclk);
      if (two) begin
         channel2_data <= w;
         channel2_input_strobe <= 1'b1;
      end else begin
         channel1_data <= w;
         channel1_input_strobe <= 1'b1;
      end
      @(posedge aclk);
      if (two) channel2_input_strobe <= 1'b0;
      else channel1_input_strobe <= 1'b0;
      @(posedge aclk);
      // Released lines show the inverse, not the old word
      if (two) channel2_data <= ~w;
      else channel1_data <= ~w;
   endtask
   // clock rises whole cycles after the strobe
   task automatic upd(input logic two);
      @(posedge aclk);
      if (two) channel2_update_clock <= 1'b1;
      else channel1_update_clock <= 1'b1;
      @(posedge aclk);
      if (two) channel2_update_clock <= 1'b0;
      else channel1_update_clock <= 1'b0;
   endtask
endmodule // sample_source

// >>> dv/tb_top.sv
`timescale 1ns/1ns
module tb_top;
   logic aclk, aresetn, look;
   logic [4:0] s_axi_awaddr, s_axi_araddr;
   logic [31:0] s_axi_wdata, s_axi_rdata;
   logic [3:0] s_axi_wstrb;
   logic [1:0] s_axi_bresp, s_axi_rresp, input_ready;
   logic s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid, s_axi_bready;
   logic s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready, current_enable, low_power_state;
   logic port_mode_select, channel1_input_strobe, channel1_update_clock, channel2_input_strobe;
   logic channel2_update_clock, power_down;
   logic [7:0] channel1_data, channel2_data, true_current_output_1, complement_current_output_1;
   logic [7:0] true_current_output_2, complement_current_output_2, a, b, c, d;
   logic [33:0] notes[$];
   int err_total, checked, seed, i;
   dual_dac_input_latch_interface #(.WAKE_CYCLES(4)) dut_u (.aclk, .aresetn, .s_axi_awaddr, .s_axi_awvalid,
      .s_axi_awready, .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid,
      .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid,
      .s_axi_rready, .port_mode_select, .channel1_data, .channel2_data, .channel1_input_strobe,
      .channel1_update_clock, .channel2_input_strobe, .channel2_update_clock, .power_down, .input_ready,
      .true_current_output_1, .complement_current_output_1, .true_current_output_2,
      .complement_current_output_2, .current_enable, .low_power_state);
   sample_source drv_u (.aclk, .port_mode_select, .channel1_data, .channel2_data, .channel1_input_strobe,
      .channel1_update_clock, .channel2_input_strobe, .channel2_update_clock, .power_down);
   initial begin
      aclk = 1'b0;
      forever #5 aclk = ~aclk;
   end
   task automatic finish_test;
      $display("Comparisons %0d mismatches %0d", checked, err_total);
      if (err_total == 0 && checked > 0) $display("TEST PASSED");
      else $display("TEST FAILED");
      $finish;
   endtask
   initial begin
      #300000;
      err_total = err_total + 1;
      finish_test;
   end
   // ****************
   // Result watcher
   // ****************
   always @(posedge aclk) begin
      logic [33:0] got, exp;
      got = look ? {2'h0, true_current_output_1, complement_current_output_1, true_current_output_2,
         complement_current_output_2} : s_axi_rvalid ? {s_axi_rresp, s_axi_rdata} : {s_axi_bresp, 32'h0};
      if (look || (s_axi_rvalid && s_axi_rready) || (s_axi_bvalid && s_axi_bready)) begin
         exp = notes.pop_front();
         checked = checked + 1;
         if (got !== exp) begin
            err_total = err_total + 1;
            $display("CHECK FAILED at %0t: got %h expected %h", $time, got, exp);
         end
      end
   end
   task automatic see(input logic [31:0] e);
      notes.push_back({2'h0, e});
      @(posedge aclk);
      look <= 1'b1;
      @(posedge aclk);
      look <= 1'b0;
   endtask
   task automatic rd(input logic [4:0] ad, input logic [33:0] e);
      notes.push_back(e);
      @(posedge aclk);
      s_axi_araddr <= ad;
      s_axi_arvalid <= 1'b1;
      s_axi_rready <= 1'b1;
      do begin
         @(posedge aclk);
         if (s_axi_arready) s_axi_arvalid <= 1'b0;
      end while (!s_axi_rvalid);
      s_axi_rready <= 1'b0;
   endtask
   task automatic wr(input logic [4:0] ad, input logic [31:0] v);
      notes.push_back(34'h0);
      @(posedge aclk);
      s_axi_awaddr <= ad;
      s_axi_wdata <= v;
      {s_axi_awvalid, s_axi_wvalid, s_axi_bready} <= 3'h7;
      do begin
         @(posedge aclk);
         if (s_axi_awready) s_axi_awvalid <= 1'b0;
         if (s_axi_wready) s_axi_wvalid <= 1'b0;
      end while (!s_axi_bvalid);
      s_axi_bready <= 1'b0;
   endtask
   task automatic cycle(input logic two);
      drv_u.upd(two);
      repeat (2) @(posedge aclk);
   endtask
   initial begin
      seed = 32'h312a;
      {aresetn, look, s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = 7'h0;
      {s_axi_awaddr, s_axi_araddr, s_axi_wdata} = 42'h0;
      s_axi_wstrb = 4'hF;
      repeat (12) @(posedge aclk);
      aresetn <= 1'b1;
      rd(5'h08, 34'h0);
      rd(5'h04, 34'h35);
      rd(5'h14, {2'h2, 32'h0});
      rd(5'h02, {2'h2, 32'h0});
      for (i = 0; i < 4; i++) begin
         a = (i == 0) ? 8'hFF : 8'($random(seed));
         b = (i == 0) ? 8'h00 : 8'($random(seed));
         drv_u.put(1'b0, a);
         drv_u.put(1'b1, b);
         drv_u.upd(1'b0);
         cycle(1'b1);
         see({a, 8'hFF - a, b, 8'hFF - b});
         rd(5'h08, {18'h3, a, a});
      end
      drv_u.power_down <= 1'b1;
      repeat (3) @(posedge aclk);
      see(32'h0);
      rd(5'h04, 34'h33);
      drv_u.power_down <= 1'b0;
      for (i = 0; i < 100 && current_enable !== 1'b1; i++) @(posedge aclk);
      repeat (2) @(posedge aclk);
      see({a, 8'hFF - a, b, 8'hFF - b});
      drv_u.port_mode_select <= 1'b0;
      @(posedge aclk);
      drv_u.channel2_update_clock <= 1'b1;
      for (i = 0; i < 2; i++) begin
         c = 8'($random(seed));
         d = 8'($random(seed));
         // select moves only while strobe and clock are low
         drv_u.channel2_input_strobe <= 1'b1;
         drv_u.put(1'b0, c);
         drv_u.channel2_input_strobe <= 1'b0;
         drv_u.put(1'b0, d);
         if (i == 0) begin
            cycle(1'b0);
            see({a, 8'hFF - a, b, 8'hFF - b});
            drv_u.channel2_update_clock <= 1'b0;
         end
         cycle(1'b0);
         if (i == 1) see({a, 8'hFF - a, b, 8'hFF - b});
         if (i == 1) cycle(1'b0);
         see({c, 8'hFF - c, d, 8'hFF - d});
         a = c;
         b = d;
      end
      // Stalled drain must keep both buffered words
      drv_u.port_mode_select <= 1'b1;
      wr(5'h00, 32'h3);
      rd(5'h00, 34'h3);
      for (i = 0; i < 3; i++) begin
         c = 8'($random(seed));
         drv_u.put(1'b0, c);
         if (i == 1) d = c;
      end
      rd(5'h04, 34'h63);
      wr(5'h04, 32'h40);
      wr(5'h00, 32'h0);
      repeat (4) @(posedge aclk);
      rd(5'h04, 34'h35);
      cycle(1'b0);
      see({d, 8'hFF - d, b, 8'hFF - b});
      finish_test;
   end
endmodule // tb_top

// >>> src/axil_slave.sv
`timescale 1ns/1ns
`include "dac_defs.svh"
module axil_slave #(
   parameter int ADDR_W = `AXI_ADDR_W
) (
   input wire logic aclk,
   input wire logic aresetn,
   input wire logic [ADDR_W-1:0] s_axi_awaddr,
   input wire logic s_axi_awvalid,
   output logic s_axi_awready,
   input wire logic [31:0] s_axi_wdata,
   input wire logic [3:0] s_axi_wstrb,
   input wire logic s_axi_wvalid,
   output logic s_axi_wready,
   output logic [1:0] s_axi_bresp,
   output logic s_axi_bvalid,
   input wire logic s_axi_bready,
   input wire logic [ADDR_W-1:0] s_axi_araddr,
   input wire logic s_axi_arvalid,
   output logic s_axi_arready,
   output logic [31:0] s_axi_rdata,
   output logic [1:0] s_axi_rresp,
   output logic s_axi_rvalid,
   input wire logic s_axi_rready,
   output logic wr_en,
   output logic [ADDR_W-1:0] wr_addr,
   output logic [31:0] wr_data,
   output logic [3:0] wr_strb,
   input wire logic wr_ok,
   output logic [ADDR_W-1:0] rd_addr,
   input wire logic [31:0] rd_data,
   input wire logic rd_ok
);
   logic aw_full;
   logic w_full;

   // Address and data taken in either order; held until response
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         aw_full <= 1'b0;
         s_axi_awready <= 1'b0;
         wr_addr <= '0;
      end else if (s_axi_awvalid && s_axi_awready) begin
         aw_full <= 1'b1;
         s_axi_awready <= 1'b0;
         wr_addr <= s_axi_awaddr;
      end else if (s_axi_bvalid && s_axi_bready) begin
         aw_full <= 1'b0;
         s_axi_awready <= 1'b1;
      end else if (!aw_full && !s_axi_bvalid) begin
         s_axi_awready <= 1'b1;
      end
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         w_full <= 1'b0;
         s_axi_wready <= 1'b0;
         wr_data <= '0;
         wr_strb <= '0;
      end else if (s_axi_wvalid && s_axi_wready) begin
         w_full <= 1'b1;
         s_axi_wready <= 1'b0;
         wr_data <= s_axi_wdata;
         wr_strb <= s_axi_wstrb;
      end else if (s_axi_bvalid && s_axi_bready) begin
         w_full <= 1'b0;
         s_axi_wready <= 1'b1;
      end else if (!w_full && !s_axi_bvalid) begin
         s_axi_wready <= 1'b1;
      end
   end

   assign wr_en = aw_full && w_full && !s_axi_bvalid;

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         s_axi_bvalid <= 1'b0;
         s_axi_bresp <= `RESP_OKAY;
      end else if (wr_en) begin
         s_axi_bvalid <= 1'b1;
         s_axi_bresp <= wr_ok ? `RESP_OKAY : `RESP_SLVERR;
      end else if (s_axi_bready) begin
         s_axi_bvalid <= 1'b0;
      end
   end

   assign rd_addr = s_axi_araddr;

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         s_axi_arready <= 1'b0;
         s_axi_rvalid <= 1'b0;
         s_axi_rdata <= '0;
         s_axi_rresp <= `RESP_OKAY;
      end else if (s_axi_arvalid && s_axi_arready) begin
         s_axi_arready <= 1'b0;
         s_axi_rvalid <= 1'b1;
         s_axi_rdata <= rd_ok ? rd_data : 32'h0000_0000;
         s_axi_rresp <= rd_ok ? `RESP_OKAY : `RESP_SLVERR;
      end else if (s_axi_rvalid && s_axi_rready) begin
         s_axi_rvalid <= 1'b0;
         s_axi_arready <= 1'b1;
      end else if (!s_axi_rvalid) begin
         s_axi_arready <= 1'b1;
      end
   end
endmodule // axil_slave

// >>> src/dac_defs.svh
`ifndef DAC_DEFS_SVH
`define DAC_DEFS_SVH

// ***************
// Timing
// ***************
`define CLK_PERIOD_NS 10
`define MAX_UPDATE_MSPS 125
`define POWER_DOWN_NS 50
`define POWER_UP_NS 5000
`define POWER_DOWN_CYCLES ((`POWER_DOWN_NS) / (`CLK_PERIOD_NS))
`define WAKE_CYCLES (((`POWER_UP_NS) + (`CLK_PERIOD_NS) - 1) / (`CLK_PERIOD_NS))

// ***************
// Structure
// ***************
`define CODE_W 8
`define BUF_DEPTH 2
`define AXI_ADDR_W 5
`define FULL_SCALE_CODE 8'hFF

// ***************
// Register map
// ***************
`define REG_CTRL 5'h00
`define REG_STATUS 5'h04
`define REG_CH1 5'h08
`define REG_CH2 5'h0C
`define REG_UPDATES 5'h10
`define CTRL_SOFT_SLEEP 0
`define CTRL_DRAIN_HOLD 1
`define CTRL_RESET 2'h0
`define STATUS_MODE 0
`define STATUS_LOW_POWER 1
`define STATUS_CURRENT_ON 2
`define STATUS_PHASE 3
`define STATUS_READY_LSB 4
`define STATUS_OVERRUN_LSB 6
`define CH_VALID_IN 16
`define CH_VALID_CONV 17
`define RESP_OKAY 2'h0
`define RESP_SLVERR 2'h2

`endif

// >>> src/dac_pkg.sv
package dac_pkg;
   typedef logic [7:0] code_t;
   typedef enum logic [2:0] {
      PWR_ON = 3'b001,
      PWR_OFF = 3'b010,
      PWR_WAKE = 3'b100
   } pwr_state_e;
endpackage

// >>> src/dual_dac_input_latch_interface.sv
// Local design decisions: the address map and the AXI4-Lite interface to the registers.
`timescale 1ns/1ns
`include "dac_defs.svh"
module dual_dac_input_latch_interface #(
   parameter int WAKE_CYCLES = `WAKE_CYCLES,
   parameter int BUF_DEPTH = `BUF_DEPTH,
   parameter int ADDR_W = `AXI_ADDR_W
) (
   input wire logic aclk,
   input wire logic aresetn,
   input wire logic [ADDR_W-1:0] s_axi_awaddr,
   input wire logic s_axi_awvalid,
   output logic s_axi_awready,
   input wire logic [31:0] s_axi_wdata,
   input wire logic [3:0] s_axi_wstrb,
   input wire logic s_axi_wvalid,
   output logic s_axi_wready,
   output logic [1:0] s_axi_bresp,
   output logic s_axi_bvalid,
   input wire logic s_axi_bready,
   input wire logic [ADDR_W-1:0] s_axi_araddr,
   input wire logic s_axi_arvalid,
   output logic s_axi_arready,
   output logic [31:0] s_axi_rdata,
   output logic [1:0] s_axi_rresp,
   output logic s_axi_rvalid,
   input wire logic s_axi_rready,
   input wire logic port_mode_select,
   input wire logic [7:0] channel1_data,
   input wire logic [7:0] channel2_data,
   input wire logic channel1_input_strobe,
   input wire logic channel1_update_clock,
   input wire logic channel2_input_strobe,
   input wire logic channel2_update_clock,
   input wire logic power_down,
   output logic [1:0] input_ready,
   output logic [7:0] true_current_output_1,
   output logic [7:0] complement_current_output_1,
   output logic [7:0] true_current_output_2,
   output logic [7:0] complement_current_output_2,
   output logic current_enable,
   output logic low_power_state
);
   localparam int WC_W = $clog2(WAKE_CYCLES + 1);

   // ***************
   // Elaboration checks
   // ***************
   if (WAKE_CYCLES < 1 || `POWER_DOWN_CYCLES < 1 || ADDR_W < 5) begin : g_bad
      $error("dual_dac_input_latch_interface: unsupported parameter values");
   end

   // ***************
   // Pin edge detection
   // ***************
   logic [3:0] pin_prev;
   logic [3:0] pin_now;
   logic [3:0] rise;
   logic interleaved;
   logic select_level;
   logic phase_reset;

   assign pin_now = {channel2_update_clock, channel2_input_strobe, channel1_update_clock, channel1_input_strobe};
   assign rise = pin_now & ~pin_prev;
   assign interleaved = !port_mode_select;
   assign select_level = channel2_input_strobe;
   assign phase_reset = channel2_update_clock;

   // Pins sampled once; edges visible only up to half the clock rate
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         pin_prev <= 4'hF;
      end else begin
         pin_prev <= pin_now;
      end
   end

   // ***************
   // Registers written by software
   // ***************
   logic soft_sleep;
   logic drain_hold;
   logic [1:0] overrun;
   logic wr_en;
   logic [ADDR_W-1:0] wr_addr;
   logic [31:0] wr_data;
   logic [3:0] wr_strb;
   logic [ADDR_W-1:0] rd_addr;
   logic [31:0] rd_data;

   function automatic logic reg_mapped(input logic [ADDR_W-1:0] a);
      reg_mapped = (a[1:0] == 2'h0) && (a <= ADDR_W'(`REG_UPDATES));
   endfunction

   function automatic logic reg_hit(input logic [ADDR_W-1:0] a, input logic [ADDR_W-1:0] r);
      reg_hit = (a == r);
   endfunction

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         {drain_hold, soft_sleep} <= `CTRL_RESET;
      end else if (wr_en && wr_strb[0] && reg_hit(wr_addr, ADDR_W'(`REG_CTRL))) begin
         soft_sleep <= wr_data[`CTRL_SOFT_SLEEP];
         drain_hold <= wr_data[`CTRL_DRAIN_HOLD];
      end
   end

   // ***************
   // Capture into the two-entry buffers
   // ***************
   logic [1:0] push;
   logic [7:0] push_data [2];
   logic [1:0] buf_ready;
   logic [1:0] pop_valid;
   logic [7:0] pop_data [2];
   logic drain_en;

   assign push[0] = interleaved ? (rise[0] && select_level) : rise[0];
   assign push[1] = interleaved ? (rise[0] && !select_level) : rise[2];
   assign push_data[0] = channel1_data;
   assign push_data[1] = interleaved ? channel1_data : channel2_data;
   assign drain_en = !drain_hold;
   assign input_ready = buf_ready;

   for (genvar i = 0; i < 2; i++) begin : g_ch
      pair_buffer #(
         .WIDTH(`CODE_W),
         .DEPTH(BUF_DEPTH)
      ) u_buf (
         .aclk(aclk),
         .aresetn(aresetn),
         .in_valid(push[i]),
         .in_ready(buf_ready[i]),
         .in_data(push_data[i]),
         .out_valid(pop_valid[i]),
         .out_ready(drain_en),
         .out_data(pop_data[i])
      );
   end

   // Word offered while full is lost; sticky so software sees it
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         overrun <= 2'h0;
      end else begin
         for (int i = 0; i < 2; i++) begin
            if (push[i] && !buf_ready[i]) begin
               overrun[i] <= 1'b1;
            end else if (wr_en && wr_strb[0] && reg_hit(wr_addr, ADDR_W'(`REG_STATUS))
                         && wr_data[`STATUS_OVERRUN_LSB + i]) begin
               overrun[i] <= 1'b0;
            end
         end
      end
   end

   // ***************
   // Input latches and converter latches
   // ***************
   dac_pkg::code_t in_latch [2];
   dac_pkg::code_t conv_latch [2];
   logic [1:0] in_valid;
   logic [1:0] conv_valid;
   logic [1:0] load;
   logic iq_phase;
   logic iq_load;
   logic [15:0] update_count;

   assign iq_load = interleaved && rise[1] && !phase_reset && !iq_phase;
   assign load[0] = interleaved ? iq_load : rise[1];
   assign load[1] = interleaved ? iq_load : rise[3];

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         iq_phase <= 1'b0;
      end else if (!interleaved || phase_reset) begin
         iq_phase <= 1'b0;
      end else if (rise[1]) begin
         iq_phase <= !iq_phase;
      end
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         for (int i = 0; i < 2; i++) begin
            in_latch[i] <= 8'h00;
            conv_latch[i] <= 8'h00;
         end
         in_valid <= 2'h0;
         conv_valid <= 2'h0;
      end else begin
         for (int i = 0; i < 2; i++) begin
            if (pop_valid[i] && drain_en) begin
               in_latch[i] <= pop_data[i];
               in_valid[i] <= 1'b1;
            end
            if (load[i]) begin
               conv_latch[i] <= in_latch[i];
               conv_valid[i] <= in_valid[i];
            end
         end
      end
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         update_count <= 16'h0000;
      end else if (load[0]) begin
         update_count <= update_count + 16'h0001;
      end
   end

   // ***************
   // Power-down sequencing
   // ***************
   dac_pkg::pwr_state_e pwr_state;
   logic sleep_req;
   logic [WC_W-1:0] wake_count;

   assign sleep_req = power_down || soft_sleep;

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         pwr_state <= dac_pkg::PWR_ON;
         wake_count <= '0;
      end else begin
         unique case (pwr_state)
            dac_pkg::PWR_ON: begin
               if (sleep_req) begin
                  pwr_state <= dac_pkg::PWR_OFF;
               end
            end
            dac_pkg::PWR_OFF: begin
               wake_count <= '0;
               if (!sleep_req) begin
                  pwr_state <= dac_pkg::PWR_WAKE;
               end
            end
            dac_pkg::PWR_WAKE: begin
               if (sleep_req) begin
                  pwr_state <= dac_pkg::PWR_OFF;
               end else if (wake_count == WC_W'(WAKE_CYCLES - 1)) begin
                  pwr_state <= dac_pkg::PWR_ON;
               end else begin
                  wake_count <= wake_count + WC_W'(1);
               end
            end
            default: begin
               pwr_state <= dac_pkg::PWR_OFF;
            end
         endcase
      end
   end

   // ***************
   // Output codes
   // ***************
   // complementary codes
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         current_enable <= 1'b0;
         low_power_state <= 1'b0;
         true_current_output_1 <= 8'h00;
         complement_current_output_1 <= 8'h00;
         true_current_output_2 <= 8'h00;
         complement_current_output_2 <= 8'h00;
      end else begin
         current_enable <= (pwr_state == dac_pkg::PWR_ON) && !sleep_req;
         low_power_state <= (pwr_state != dac_pkg::PWR_ON) || sleep_req;
         if ((pwr_state == dac_pkg::PWR_ON) && !sleep_req) begin
            true_current_output_1 <= conv_latch[0];
            complement_current_output_1 <= `FULL_SCALE_CODE - conv_latch[0];
            true_current_output_2 <= conv_latch[1];
            complement_current_output_2 <= `FULL_SCALE_CODE - conv_latch[1];
         end else begin
            true_current_output_1 <= 8'h00;
            complement_current_output_1 <= 8'h00;
            true_current_output_2 <= 8'h00;
            complement_current_output_2 <= 8'h00;
         end
      end
   end

   // ***************
   // Register read and bus slave
   // ***************
   always_comb begin
      rd_data = 32'h0000_0000;
      unique case (1'b1)
         reg_hit(rd_addr, ADDR_W'(`REG_CTRL)): begin
            rd_data[`CTRL_SOFT_SLEEP] = soft_sleep;
            rd_data[`CTRL_DRAIN_HOLD] = drain_hold;
         end
         reg_hit(rd_addr, ADDR_W'(`REG_STATUS)): begin
            rd_data[`STATUS_MODE] = port_mode_select;
            rd_data[`STATUS_LOW_POWER] = low_power_state;
            rd_data[`STATUS_CURRENT_ON] = current_enable;
            rd_data[`STATUS_PHASE] = iq_phase;
            rd_data[`STATUS_READY_LSB +: 2] = buf_ready;
            rd_data[`STATUS_OVERRUN_LSB +: 2] = overrun;
         end
         reg_hit(rd_addr, ADDR_W'(`REG_CH1)): begin
            rd_data[15:0] = {conv_latch[0], in_latch[0]};
            rd_data[`CH_VALID_IN] = in_valid[0];
            rd_data[`CH_VALID_CONV] = conv_valid[0];
         end
         reg_hit(rd_addr, ADDR_W'(`REG_CH2)): begin
            rd_data[15:0] = {conv_latch[1], in_latch[1]};
            rd_data[`CH_VALID_IN] = in_valid[1];
            rd_data[`CH_VALID_CONV] = conv_valid[1];
         end
         reg_hit(rd_addr, ADDR_W'(`REG_UPDATES)): begin
            rd_data[15:0] = update_count;
         end
         default: begin
            rd_data = 32'h0000_0000;
         end
      endcase
   end

   axil_slave #(
      .ADDR_W(ADDR_W)
   ) u_axil (
      .aclk(aclk),
      .aresetn(aresetn),
      .s_axi_awaddr(s_axi_awaddr),
      .s_axi_awvalid(s_axi_awvalid),
      .s_axi_awready(s_axi_awready),
      .s_axi_wdata(s_axi_wdata),
      .s_axi_wstrb(s_axi_wstrb),
      .s_axi_wvalid(s_axi_wvalid),
      .s_axi_wready(s_axi_wready),
      .s_axi_bresp(s_axi_bresp),
      .s_axi_bvalid(s_axi_bvalid),
      .s_axi_bready(s_axi_bready),
      .s_axi_araddr(s_axi_araddr),
      .s_axi_arvalid(s_axi_arvalid),
      .s_axi_arready(s_axi_arready),
      .s_axi_rdata(s_axi_rdata),
      .s_axi_rresp(s_axi_rresp),
      .s_axi_rvalid(s_axi_rvalid),
      .s_axi_rready(s_axi_rready),
      .wr_en(wr_en),
      .wr_addr(wr_addr),
      .wr_data(wr_data),
      .wr_strb(wr_strb),
      .wr_ok(reg_mapped(wr_addr)),
      .rd_addr(rd_addr),
      .rd_data(rd_data),
      .rd_ok(reg_mapped(rd_addr))
   );
endmodule // dual_dac_input_latch_interface

// >>> src/pair_buffer.sv
`timescale 1ns/1ns
module pair_buffer #(
   parameter int WIDTH = 8,
   parameter int DEPTH = 2
) (
   input wire logic aclk,
   input wire logic aresetn,
   input wire logic in_valid,
   output logic in_ready,
   input wire logic [WIDTH-1:0] in_data,
   output logic out_valid,
   input wire logic out_ready,
   output logic [WIDTH-1:0] out_data
);
   localparam int PW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
   localparam int CW = $clog2(DEPTH + 1);

   if (WIDTH < 1 || DEPTH < 2 || (DEPTH & (DEPTH - 1)) != 0) begin : g_bad
      $error("pair_buffer needs WIDTH >= 1 and DEPTH a power of two >= 2");
   end

   logic [WIDTH-1:0] mem [DEPTH];
   logic [PW-1:0] wr_ptr;
   logic [PW-1:0] rd_ptr;
   logic [CW-1:0] count;
   logic [CW-1:0] next_count;
   logic push;
   logic pop;

   assign push = in_valid && in_ready;
   assign pop = out_valid && out_ready;
   assign out_data = mem[rd_ptr];

   always_comb begin
      next_count = count;
      if (push && !pop) begin
         next_count = count + CW'(1);
      end else if (pop && !push) begin
         next_count = count - CW'(1);
      end
   end

   // Flags registered from the next count, so ready never lags
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         count <= '0;
         in_ready <= 1'b0;
         out_valid <= 1'b0;
      end else begin
         count <= next_count;
         in_ready <= (next_count != CW'(DEPTH));
         out_valid <= (next_count != '0);
      end
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         wr_ptr <= '0;
         rd_ptr <= '0;
      end else begin
         if (push) begin
            wr_ptr <= wr_ptr + PW'(1);
         end
         if (pop) begin
            rd_ptr <= rd_ptr + PW'(1);
         end
      end
   end

   always_ff @(posedge aclk) begin
      if (push) begin
         mem[wr_ptr] <= in_data;
      end
   end
endmodule // pair_buffer
